// >>> design/eal_defines.vh
// constants for the effective address and program linkage sequencer
// assumes words are 24 bits, with bit 23 of a vector holding word bit 0
// Overview of operation
// - nonzero tag adds index base to address
// - tag 01 first index, 10 second
// - opcode bits 3-8, address bits 9-23
// - index holds 15-bit base, 9-bit step
// - base plus sign-extended step written back
// - terminal when base leaves 0..077777 range
// - terminal falls through, else branch taken
// - direct mode uses indexed address as operand
// - indirect word re-decoded, any number levels
// - each indirect level costs one memory cycle
// - mark branch saves own address, branches onward
// - mark branch stores flags in bits 3-8
// - return branch resumes at saved address plus one
// - return branch merges saved flags into flags
// - argument branch stores p+1 indirect, clears flags
// - interrupt return branches and signals completion
// - overflow bit on add, subtract, negate overflow
// - overflow when both multiply operands most negative
// - overflow when dividend magnitude not below divisor
// - overflow when left shift changes sign
// - overflow sticky until flag clear or argument branch instruction
// - repeat steps first index, counts with second
// - unsuccessful repeated search exits after repeat
`ifndef EAL_DEFINES_VH
`define EAL_DEFINES_VH

// ********************************************************
// word field positions (vector bit = 23 - word bit)
// ********************************************************
`define EAL_IND_BIT      23
`define EAL_TAG_MSB      22
`define EAL_TAG_LSB      21
`define EAL_OP_MSB       20
`define EAL_OP_LSB       15
`define EAL_ADR_MSB      14
`define EAL_ADR_LSB      0
`define EAL_STEP_MSB     23
`define EAL_STEP_LSB     15
`define EAL_SHIFT_MSB    4

// ********************************************************
// values
// ********************************************************
`define EAL_TAG_FIRST    2'h1
`define EAL_TAG_SECOND   2'h2
`define EAL_TAG_THIRD    2'h3
`define EAL_OVF_BIT      5
`define EAL_MOST_NEG     24'h800000
`define EAL_WORD_RST     24'h000000
`define EAL_PC_RST       15'h0000
`define EAL_FLAGS_RST    6'h00

// ********************************************************
// operation codes
// ********************************************************
`define EAL_OP_LOAD_ACCUMULATOR         6'h0e
`define EAL_OP_STORE_ACC                6'h0f
`define EAL_OP_ADD                      6'h10
`define EAL_OP_SUBTRACT                 6'h11
`define EAL_OP_NEGATE                   6'h12
`define EAL_OP_DOUBLE_ADD               6'h13
`define EAL_OP_MULTIPLY                 6'h14
`define EAL_OP_DIVIDE                   6'h15
`define EAL_OP_SHIFT_LEFT               6'h16
`define EAL_OP_SKIP_EQUAL               6'h17
`define EAL_OP_LOAD_INDEX               6'h18
`define EAL_OP_STORE_INDEX              6'h19
`define EAL_OP_INCREMENT_INDEX_BRANCH   6'h1a
`define EAL_OP_MARK_AND_BRANCH          6'h1b
`define EAL_OP_ARGUMENT_ADDRESS_BRANCH  6'h1c
`define EAL_OP_RETURN_BRANCH            6'h1d
`define EAL_OP_BRANCH_CLEAR_INTERRUPT   6'h1e
`define EAL_OP_BRANCH                   6'h1f
`define EAL_OP_REPEAT_INSTRUCTION       6'h20
`define EAL_OP_FLAG_CLEAR               6'h21
`define EAL_OP_FLAG_SET                 6'h22

`endif

// >>> design/eal_index_alu.v
// index register step and terminal test
// assumes a 15-bit base and a 9-bit two's complement step
`timescale 1ns/1ps
`include "eal_defines.vh"
module eal_index_alu
(
  input  wire [23:0] index_i,
  output wire [14:0] new_base_o,
  output wire        terminal_o
);

  // ********************************************************
  // step and range test
  // ********************************************************
  wire [8:0]  step_w;
  wire [15:0] sum_w;

  assign step_w = index_i[`EAL_STEP_MSB:`EAL_STEP_LSB];
  // sign extended six places plus one guard bit for the test
  assign sum_w = {1'b0, index_i[`EAL_ADR_MSB:`EAL_ADR_LSB]} +
                 {{7{step_w[8]}}, step_w};
  assign new_base_o = sum_w[14:0];
  // borrow below zero or carry above 077777 both land in bit 15
  assign terminal_o = sum_w[15];

endmodule // eal_index_alu

// >>> design/eal_core.v
// address generation, indirect chain, linkage, overflow and repeat
// assumes a single-port memory on clk_i answering with mem_ack_i
`timescale 1ns/1ps
`include "eal_defines.vh"
module eal_core
(
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        mem_ack_i,
  input  wire [23:0] mem_rdata_i,
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg  [14:0] mem_addr_o,
  output reg  [23:0] mem_wdata_o,
  output reg         int_done_o,
  output reg  [14:0] pc_o,
  output reg  [5:0]  flags_o,
  output reg  [23:0] acc_a_o,
  output reg  [23:0] acc_b_o,
  output wire [23:0] index_one_o,
  output wire [23:0] index_two_o,
  output wire [23:0] index_three_o
);

  // ********************************************************
  // states
  // ********************************************************
  localparam [8:0] ST_IFETCH  = 9'h001;
  localparam [8:0] ST_IWAIT   = 9'h002;
  localparam [8:0] ST_DECODE  = 9'h004;
  localparam [8:0] ST_INDWAIT = 9'h008;
  localparam [8:0] ST_OPWAIT  = 9'h010;
  localparam [8:0] ST_OP2WAIT = 9'h020;
  localparam [8:0] ST_EXEC    = 9'h040;
  localparam [8:0] ST_WWAIT   = 9'h080;
  localparam [8:0] ST_REPSTEP = 9'h100;

  // ********************************************************
  // reset release
  // ********************************************************
  reg  [1:0] rst_sync_r;
  wire       rst_n;

  // assert at once, release after two edges
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  assign rst_n = rst_sync_r[1];

  // ********************************************************
  // state and registers
  // ********************************************************
  reg  [8:0]  state_r;
  reg  [23:0] ir_r;          // instruction, or repeated one
  reg  [23:0] aw_r;          // word of the current address level
  reg         first_r;       // current level is the instruction itself
  reg  [14:0] ea_r;
  reg  [23:0] opnd_r;
  reg  [23:0] opnd2_r;
  reg  [23:0] xr_r [0:2];
  reg         rep_r;
  reg  [14:0] rep_pc_r;
  reg         skip_r;

  assign index_one_o   = xr_r[0];
  assign index_two_o   = xr_r[1];
  assign index_three_o = xr_r[2];

  // ********************************************************
  // decode
  // ********************************************************
  wire [5:0]  op_w;
  wire [1:0]  tag_w;
  wire        is_xop_w;
  wire        needs_rd_w;
  wire        needs_wr_w;
  reg  [1:0]  lvl_tag;
  reg  [14:0] lvl_base;
  wire [14:0] ea_calc_w;
  reg  [23:0] x_tgt;
  wire [1:0]  tgt_idx_w;

  assign op_w  = ir_r[`EAL_OP_MSB:`EAL_OP_LSB];
  assign tag_w = ir_r[`EAL_TAG_MSB:`EAL_TAG_LSB];
  assign tgt_idx_w = tag_w - 2'h1;
  // these three name their target register with the tag
  assign is_xop_w = (op_w == `EAL_OP_LOAD_INDEX) ||
                    (op_w == `EAL_OP_STORE_INDEX) ||
                    (op_w == `EAL_OP_INCREMENT_INDEX_BRANCH);
  assign needs_rd_w = (op_w == `EAL_OP_LOAD_ACCUMULATOR) ||
                      (op_w == `EAL_OP_ADD) ||
                      (op_w == `EAL_OP_SUBTRACT) ||
                      (op_w == `EAL_OP_DOUBLE_ADD) ||
                      (op_w == `EAL_OP_MULTIPLY) ||
                      (op_w == `EAL_OP_DIVIDE) ||
                      (op_w == `EAL_OP_SKIP_EQUAL) ||
                      (op_w == `EAL_OP_LOAD_INDEX) ||
                      (op_w == `EAL_OP_RETURN_BRANCH) ||
                      (op_w == `EAL_OP_BRANCH_CLEAR_INTERRUPT) ||
                      (op_w == `EAL_OP_REPEAT_INSTRUCTION);
  assign needs_wr_w = (op_w == `EAL_OP_STORE_ACC) ||
                      (op_w == `EAL_OP_STORE_INDEX) ||
                      (op_w == `EAL_OP_MARK_AND_BRANCH) ||
                      (op_w == `EAL_OP_ARGUMENT_ADDRESS_BRANCH);

  // index chosen for this level; a repeated instruction uses the first
  always @*
  begin
    lvl_tag = aw_r[`EAL_TAG_MSB:`EAL_TAG_LSB];
    if (first_r && is_xop_w)
      lvl_tag = 2'h0;
    else if (first_r && rep_r)
      lvl_tag = `EAL_TAG_FIRST;
    case (lvl_tag)
      `EAL_TAG_FIRST:  lvl_base = xr_r[0][`EAL_ADR_MSB:0];
      `EAL_TAG_SECOND: lvl_base = xr_r[1][`EAL_ADR_MSB:0];
      `EAL_TAG_THIRD:  lvl_base = xr_r[2][`EAL_ADR_MSB:0];
      default:         lvl_base = 15'h0000;
    endcase
  end
  // address wraps at 077777, like the circular memory
  assign ea_calc_w = aw_r[`EAL_ADR_MSB:`EAL_ADR_LSB] + lvl_base;

  // target index register of an index instruction
  always @*
  begin
    case (tag_w)
      `EAL_TAG_FIRST:  x_tgt = xr_r[0];
      `EAL_TAG_SECOND: x_tgt = xr_r[1];
      `EAL_TAG_THIRD:  x_tgt = xr_r[2];
      default:         x_tgt = `EAL_WORD_RST;
    endcase
  end

  // ********************************************************
  // index step unit, shared by index branch and repeat
  // ********************************************************
  wire [23:0] step_in_w;
  wire [14:0] new_base_w;
  wire        terminal_w;

  assign step_in_w = (state_r == ST_REPSTEP) ? xr_r[0] : x_tgt;

  eal_index_alu u_step
  (
    .index_i    (step_in_w),
    .new_base_o (new_base_w),
    .terminal_o (terminal_w)
  );

  // ********************************************************
  // arithmetic
  // ********************************************************
  wire [24:0] add_w;
  wire [24:0] sub_w;
  wire [48:0] dadd_w;
  wire signed [47:0] prod_w;
  wire [23:0] a_mag_w;
  wire [23:0] o_mag_w;
  wire        div_ovf_w;
  wire signed [47:0] num_w;
  wire signed [47:0] den_w;
  wire signed [47:0] quot_w;
  wire signed [47:0] rem_w;
  wire [23:0] asl_w;
  wire        mul_ovf_w;

  assign add_w  = {acc_a_o[23], acc_a_o} + {opnd_r[23], opnd_r};
  assign sub_w  = {acc_a_o[23], acc_a_o} - {opnd_r[23], opnd_r};
  assign dadd_w = {acc_a_o[23], acc_a_o, acc_b_o} +
                  {opnd_r[23], opnd_r, opnd2_r};
  assign prod_w = $signed(acc_a_o) * $signed(opnd_r);
  assign mul_ovf_w = (acc_a_o == `EAL_MOST_NEG) &&
                     (opnd_r == `EAL_MOST_NEG);
  assign a_mag_w = acc_a_o[23] ? (24'h000000 - acc_a_o) : acc_a_o;
  assign o_mag_w = opnd_r[23] ? (24'h000000 - opnd_r) : opnd_r;
  // also catches a zero divisor, so the divider never sees one
  assign div_ovf_w = (a_mag_w >= o_mag_w);
  assign num_w = {acc_a_o, acc_b_o};
  assign den_w = div_ovf_w ? 48'sh000000000001 :
                 {{24{opnd_r[23]}}, opnd_r};
  assign quot_w = num_w / den_w;
  assign rem_w  = num_w % den_w;
  // only the final sign is compared; long shifts may hide a flip
  assign asl_w = acc_a_o << opnd_shift(ea_r);

  function [4:0] opnd_shift;
    input [14:0] adr;
    begin
      opnd_shift = adr[`EAL_SHIFT_MSB:0];
    end
  endfunction

  // ********************************************************
  // sequencer
  // ********************************************************
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= ST_IFETCH;
      ir_r        <= `EAL_WORD_RST;
      aw_r        <= `EAL_WORD_RST;
      first_r     <= 1'b0;
      ea_r        <= `EAL_PC_RST;
      opnd_r      <= `EAL_WORD_RST;
      opnd2_r     <= `EAL_WORD_RST;
      xr_r[0]     <= `EAL_WORD_RST;
      xr_r[1]     <= `EAL_WORD_RST;
      xr_r[2]     <= `EAL_WORD_RST;
      rep_r       <= 1'b0;
      rep_pc_r    <= `EAL_PC_RST;
      skip_r      <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= `EAL_PC_RST;
      mem_wdata_o <= `EAL_WORD_RST;
      int_done_o  <= 1'b0;
      pc_o        <= `EAL_PC_RST;
      flags_o     <= `EAL_FLAGS_RST;
      acc_a_o     <= `EAL_WORD_RST;
      acc_b_o     <= `EAL_WORD_RST;
    end
    else
    begin
      int_done_o <= 1'b0;
      case (state_r)
        ST_IFETCH:
        begin
          mem_req_o  <= 1'b1;
          mem_we_o   <= 1'b0;
          mem_addr_o <= pc_o;
          state_r    <= ST_IWAIT;
        end
        ST_IWAIT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            ir_r      <= mem_rdata_i;
            aw_r      <= mem_rdata_i;
            first_r   <= 1'b1;
            state_r   <= ST_DECODE;
          end
        // one address level per pass; each indirect level is one read
        ST_DECODE:
        begin
          ea_r    <= ea_calc_w;
          first_r <= 1'b0;
          skip_r  <= 1'b0;
          if (aw_r[`EAL_IND_BIT])
          begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= ea_calc_w;
            state_r    <= ST_INDWAIT;
          end
          else if (needs_rd_w)
          begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= ea_calc_w;
            state_r    <= ST_OPWAIT;
          end
          else
            state_r <= ST_EXEC;
        end
        // fetched word is re-decoded, its opcode field ignored
        ST_INDWAIT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            aw_r      <= mem_rdata_i;
            state_r   <= ST_DECODE;
          end
        ST_OPWAIT:
          if (mem_ack_i)
          begin
            opnd_r <= mem_rdata_i;
            if (op_w == `EAL_OP_DOUBLE_ADD)
            begin
              mem_addr_o <= ea_r + 15'h0001;
              state_r    <= ST_OP2WAIT;
            end
            else
            begin
              mem_req_o <= 1'b0;
              state_r   <= ST_EXEC;
            end
          end
        ST_OP2WAIT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            opnd2_r   <= mem_rdata_i;
            state_r   <= ST_EXEC;
          end
        ST_EXEC:
        begin
          state_r <= rep_r ? ST_REPSTEP : ST_IFETCH;
          // the repeat loop owns the program counter while it runs
          if (!rep_r)
            pc_o <= pc_o + 15'h0001;
          if (needs_wr_w)
          begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b1;
            mem_addr_o <= ea_r;
            state_r    <= ST_WWAIT;
          end
          case (op_w)
            `EAL_OP_LOAD_ACCUMULATOR: acc_a_o <= opnd_r;
            `EAL_OP_STORE_ACC:        mem_wdata_o <= acc_a_o;
            `EAL_OP_ADD:
            begin
              acc_a_o <= add_w[23:0];
              if (add_w[24] != add_w[23])
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            `EAL_OP_SUBTRACT:
            begin
              acc_a_o <= sub_w[23:0];
              if (sub_w[24] != sub_w[23])
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            `EAL_OP_NEGATE:
            begin
              acc_a_o <= 24'h000000 - acc_a_o;
              if (acc_a_o == `EAL_MOST_NEG)
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            `EAL_OP_DOUBLE_ADD:
            begin
              acc_a_o <= dadd_w[47:24];
              acc_b_o <= dadd_w[23:0];
              if (dadd_w[48] != dadd_w[47])
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            `EAL_OP_MULTIPLY:
            begin
              acc_a_o <= prod_w[46:23];
              acc_b_o <= {prod_w[22:0], 1'b0};
              if (mul_ovf_w)
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            // on overflow the accumulators are left as they were
            `EAL_OP_DIVIDE:
              if (div_ovf_w)
                flags_o[`EAL_OVF_BIT] <= 1'b1;
              else
              begin
                acc_a_o <= quot_w[24:1];
                acc_b_o <= rem_w[23:0];
              end
            `EAL_OP_SHIFT_LEFT:
            begin
              acc_a_o <= asl_w;
              if (asl_w[23] != acc_a_o[23])
                flags_o[`EAL_OVF_BIT] <= 1'b1;
            end
            `EAL_OP_SKIP_EQUAL:
            begin
              skip_r <= (acc_a_o == opnd_r);
              if (!rep_r && (acc_a_o == opnd_r))
                pc_o <= pc_o + 15'h0002;
            end
            `EAL_OP_LOAD_INDEX:
              if (tag_w != 2'h0)
                xr_r[tgt_idx_w] <= opnd_r;
            `EAL_OP_STORE_INDEX:      mem_wdata_o <= x_tgt;
            `EAL_OP_INCREMENT_INDEX_BRANCH:
            begin
              if (tag_w != 2'h0)
                xr_r[tgt_idx_w][`EAL_ADR_MSB:0] <= new_base_w;
              if (!terminal_w)
                pc_o <= ea_r;
            end
            `EAL_OP_MARK_AND_BRANCH:
            begin
              mem_wdata_o <= {3'h0, flags_o, pc_o};
              pc_o        <= ea_r + 15'h0001;
            end
            `EAL_OP_ARGUMENT_ADDRESS_BRANCH:
            begin
              mem_wdata_o <= {1'b1, 2'h0, flags_o,
                              pc_o + 15'h0001};
              flags_o     <= `EAL_FLAGS_RST;
              pc_o        <= ea_r + 15'h0001;
            end
            `EAL_OP_RETURN_BRANCH:
            begin
              pc_o    <= opnd_r[`EAL_ADR_MSB:0] + 15'h0001;
              flags_o <= flags_o |
                         opnd_r[`EAL_OP_MSB:`EAL_OP_LSB];
            end
            `EAL_OP_BRANCH_CLEAR_INTERRUPT:
            begin
              pc_o       <= opnd_r[`EAL_ADR_MSB:0];
              flags_o    <= flags_o | opnd_r[`EAL_OP_MSB:`EAL_OP_LSB];
              int_done_o <= 1'b1;
            end
            `EAL_OP_BRANCH:           pc_o <= ea_r;
            // only this instruction and the argument branch take the overflow bit down
            `EAL_OP_FLAG_CLEAR:
              flags_o <= flags_o & ~ea_r[5:0];
            `EAL_OP_FLAG_SET:
              flags_o <= flags_o | ea_r[5:0];
            `EAL_OP_REPEAT_INSTRUCTION:
              if (!rep_r)
              begin
                rep_r    <= 1'b1;
                rep_pc_r <= pc_o;
                pc_o     <= pc_o;
                ir_r     <= opnd_r;
                aw_r     <= opnd_r;
                first_r  <= 1'b1;
                state_r  <= ST_DECODE;
              end
            default: ;
          endcase
        end
        ST_WWAIT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            state_r   <= rep_r ? ST_REPSTEP : ST_IFETCH;
          end
        // step the address index, count down the second index
        ST_REPSTEP:
        begin
          xr_r[0][`EAL_ADR_MSB:0] <= new_base_w;
          xr_r[1][`EAL_ADR_MSB:0] <=
            xr_r[1][`EAL_ADR_MSB:0] - 15'h0001;
          if (skip_r)
          begin
            rep_r   <= 1'b0;
            pc_o    <= rep_pc_r + 15'h0002;
            state_r <= ST_IFETCH;
          end
          else if (xr_r[1][`EAL_ADR_MSB:0] == 15'h0001)
          begin
            rep_r   <= 1'b0;
            pc_o    <= rep_pc_r + 15'h0001;
            state_r <= ST_IFETCH;
          end
          else
          begin
            aw_r    <= ir_r;
            first_r <= 1'b1;
            state_r <= ST_DECODE;
          end
        end
        default: state_r <= ST_IFETCH;
      endcase
    end
  end

endmodule // eal_core

// >>> verification/eal_core_props.sv
// concurrent checks on the sequencer's memory bus and flag outputs
// assumes it is bound onto eal_core, one clock, asynchronous reset
`timescale 1ns/1ps
`include "eal_defines.vh"
module eal_core_props
(
  input wire        clk_i,
  input wire        nrst_i,
  input wire        mem_ack_i,
  input wire [23:0] mem_rdata_i,
  input wire        mem_req_o,
  input wire        mem_we_o,
  input wire [14:0] mem_addr_o,
  input wire [23:0] mem_wdata_o,
  input wire        int_done_o,
  input wire [14:0] pc_o,
  input wire [5:0]  flags_o
);
  // ******************************
  // helper and assertions
  // ******************************
  reg [5:0] lop_r;
  // opcode of last fetch; data never sits at pc addresses
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      lop_r <= 6'h00;
    else if (mem_req_o && mem_ack_i && !mem_we_o && mem_addr_o == pc_o)
      lop_r <= mem_rdata_i[`EAL_OP_MSB:`EAL_OP_LSB];
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("request moved");
  chk_wdata_hold: assert property (mem_req_o && mem_we_o && !mem_ack_i
    |=> $stable(mem_wdata_o)) else $error("wdata moved");
  chk_write_drop: assert property (mem_req_o && mem_we_o && mem_ack_i
    |=> !mem_req_o) else $error("req held after ack");
  chk_done_pulse: assert property (int_done_o |=> !int_done_o)
    else $error("pulse too long");
  chk_done_cause: assert property (int_done_o |->
    lop_r == `EAL_OP_BRANCH_CLEAR_INTERRUPT) else $error("stray completion");
  chk_ovf_sticky: assert property ($fell(flags_o[`EAL_OVF_BIT]) |->
    lop_r == `EAL_OP_FLAG_CLEAR || lop_r == `EAL_OP_ARGUMENT_ADDRESS_BRANCH)
    else $error("overflow lost");
  chk_flags_merge: assert property (lop_r == `EAL_OP_RETURN_BRANCH |->
    ($past(flags_o) & ~flags_o) == 6'h00) else $error("return lost a flag");
  chk_reset_quiet: assert property (disable iff (1'b0) !nrst_i |->
    !mem_req_o && pc_o == `EAL_PC_RST && flags_o == `EAL_FLAGS_RST)
    else $error("active in reset");
endmodule // eal_core_props

// >>> verification/eal_mem_model.sv
// core memory partner: one word per request, random stall
// assumes the requester holds its request until the ack edge
`timescale 1ns/1ps
module eal_mem_model
(
  input  wire        clk_i,
  input  wire        req_i,
  input  wire        we_i,
  input  wire [14:0] addr_i,
  input  wire [23:0] wdata_i,
  input  wire        slow_i,
  output reg         ack_o,
  output reg  [23:0] rdata_o
);
  // ******************************
  // storage and answer
  // ******************************
  reg [23:0] mem [0:32767];
  integer    seed = 71303;
  integer    wait_r = 0;
  initial ack_o = 1'b0;
  initial rdata_o = 24'h000000;
  // data scrambled off the ack cycle so stale reads show
  always @(posedge clk_i)
  begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o)
    begin
      if (wait_r > 0)
        wait_r <= wait_r - 1;
      else
      begin
        ack_o  <= 1'b1;
        wait_r <= slow_i ? {$random(seed)} % 4 : 0;
        if (we_i)
          mem[addr_i] <= wdata_i;
        else
          rdata_o <= mem[addr_i];
      end
    end
  end
endmodule // eal_mem_model

// >>> verification/testbench.sv
// runs a test program through the sequencer and checks results
// assumes the core, memory model and checker are compiled first
`timescale 1ns/1ps
`include "eal_defines.vh"
module testbench;
  reg         clk_i;
  reg         nrst_i = 1'b1;
  reg         slow_r = 1'b0;
  wire        ack, req, we, done;
  wire [23:0] rdata, wdata, acc_a, acc_b, ix1, ix2, ix3;
  wire [14:0] addr, pc;
  wire [5:0]  flags;
  wire        ovf = flags[`EAL_OVF_BIT];
  integer     num_errors = 0;
  integer     samples_checked = 0;
  integer     seed = 71303;
  integer     rd_cnt = 0;
  integer     rd_mark, i;
  reg  [23:0] r0, r1, r2, key;
  eal_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .mem_ack_i(ack),
    .mem_rdata_i(rdata), .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr),
    .mem_wdata_o(wdata), .int_done_o(done), .pc_o(pc), .flags_o(flags),
    .acc_a_o(acc_a), .acc_b_o(acc_b), .index_one_o(ix1),
    .index_two_o(ix2), .index_three_o(ix3));
  eal_mem_model MEM (.clk_i(clk_i), .req_i(req), .we_i(we), .addr_i(addr),
    .wdata_i(wdata), .slow_i(slow_r), .ack_o(ack), .rdata_o(rdata));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // read counter for cycle cost checks
  always @(posedge clk_i)
  begin
    if (req && ack && !we) rd_cnt <= rd_cnt + 1;
  end
  function [23:0] ins(input ind, input [1:0] t, input [5:0] op,
                      input [14:0] a);
    ins = {ind, t, op, a};
  endfunction
  task op(input [14:0] at, input [1:0] t, input [5:0] c, input [14:0] a);
    MEM.mem[at] = {1'b0, t, c, a};
  endtask
  task check(input [23:0] got, input [23:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // bounded wait for pc; memory speed redrawn each call
  task run_to(input [14:0] a);
    integer n;
  begin
    n = 0;
    slow_r <= $random(seed);
    while (pc !== a && n < 400)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    if (n == 400)
    begin
      num_errors = num_errors + 1;
      $display("Error %0t: pc never reached %h", $time, a);
      print_verdict;
    end
  end
  endtask
  // ******************************
  // program, data and checks
  // ******************************
  initial
  begin
    nrst_i <= 1'b0;
    r0 = $random(seed); r1 = $random(seed); r2 = $random(seed);
    key = $random(seed);
    for (i = 0; i < 32768; i = i + 1) MEM.mem[i] = 24'h000000;
    MEM.mem[15'h100] = {9'h001, 15'h0003}; MEM.mem[15'h101] = {9'h1ff, 15'h0};
    MEM.mem[15'h102] = {9'h001, 15'h7fff}; MEM.mem[15'h103] = 24'h000003;
    MEM.mem[15'h104] = {9'h002, 15'h0}; MEM.mem[15'h200] = r0;
    MEM.mem[15'h210] = ins(1, 2, 0, 15'h220); MEM.mem[15'h233] = r1;
    MEM.mem[15'h220] = ins(0, 1, 0, 15'h230); MEM.mem[15'h204] = ~r1;
    MEM.mem[15'h205] = r2; MEM.mem[15'h202] = 24'h7fffff;
    MEM.mem[15'h203] = 24'h000001; MEM.mem[15'h206] = `EAL_MOST_NEG;
    MEM.mem[15'h207] = 24'h200000; MEM.mem[15'h208] = 24'h100000;
    MEM.mem[15'h209] = 24'h400000; MEM.mem[15'h20a] = key;
    for (i = 0; i < 6; i = i + 2) MEM.mem[15'h300 + i] = ~key;
    MEM.mem[15'h306] = key; MEM.mem[15'h048] = 24'h000019;
    op(0, 1, `EAL_OP_LOAD_INDEX, 15'h100);
    op(1, 2, `EAL_OP_LOAD_INDEX, 15'h101);
    op(2, 1, `EAL_OP_LOAD_ACCUMULATOR, 15'h1fd);
    MEM.mem[3] = ins(1, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h210);
    op(4, 2, `EAL_OP_INCREMENT_INDEX_BRANCH, 15'h00a);
    op(5, 1, `EAL_OP_INCREMENT_INDEX_BRANCH, 15'h007);
    op(6, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h204);
    op(7, 3, `EAL_OP_LOAD_INDEX, 15'h102);
    op(8, 3, `EAL_OP_INCREMENT_INDEX_BRANCH, 15'h00a);
    op(9, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h205);
    op(10, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h202);
    op(11, 0, `EAL_OP_ADD, 15'h203);
    op(12, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h206);
    op(13, 0, `EAL_OP_MARK_AND_BRANCH, 15'h040);
    op(15'h41, 0, `EAL_OP_RETURN_BRANCH, 15'h040);
    op(14, 0, `EAL_OP_FLAG_CLEAR, 15'h03f);
    op(15, 0, `EAL_OP_MULTIPLY, 15'h206);
    op(16, 0, `EAL_OP_ARGUMENT_ADDRESS_BRANCH, 15'h044);
    op(15'h45, 0, `EAL_OP_FLAG_SET, 15'h001);
    op(15'h46, 0, `EAL_OP_RETURN_BRANCH, 15'h044);
    op(18, 0, `EAL_OP_FLAG_CLEAR, 15'h03f);
    op(19, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h207);
    op(20, 0, `EAL_OP_DIVIDE, 15'h208);
    op(21, 0, `EAL_OP_FLAG_CLEAR, 15'h03f);
    op(22, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h209);
    op(23, 0, `EAL_OP_SHIFT_LEFT, 15'h001);
    op(24, 0, `EAL_OP_BRANCH_CLEAR_INTERRUPT, 15'h048);
    op(25, 2, `EAL_OP_LOAD_INDEX, 15'h103);
    op(26, 1, `EAL_OP_LOAD_INDEX, 15'h104);
    op(27, 0, `EAL_OP_LOAD_ACCUMULATOR, 15'h20a);
    op(28, 0, `EAL_OP_REPEAT_INSTRUCTION, 15'h04a);
    op(15'h4a, 0, `EAL_OP_SKIP_EQUAL, 15'h300);
    op(29, 0, `EAL_OP_BRANCH, 15'h01d);
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    run_to(15'h03); check(acc_a, r0);
    rd_mark = rd_cnt;
    run_to(15'h04); check(acc_a, r1);
    check(rd_cnt - rd_mark, 4);
    run_to(15'h05); check(ix2, {9'h1ff, 15'h7fff});
    run_to(15'h07); check(acc_a, r1);
    check(ix1, {9'h001, 15'h0004});
    run_to(15'h0a); check(acc_a, r2);
    check(ix3, {9'h001, 15'h0000});
    run_to(15'h0c); check(ovf, 1);
    run_to(15'h0d); check(ovf, 1);
    run_to(15'h0e); check(flags, 6'h20);
    check(MEM.mem[15'h40], {3'h0, 6'h20, 15'h000d});
    run_to(15'h0f); check(flags, 6'h00);
    run_to(15'h10); check(ovf, 1);
    run_to(15'h46); check(flags, 6'h01);
    check(MEM.mem[15'h44], {3'h4, 6'h20, 15'h0011});
    run_to(15'h12); check(flags, 6'h21);
    run_to(15'h15); check(ovf, 1);
    run_to(15'h18); check(ovf, 1);
    run_to(15'h19); check(done, 1);
    run_to(15'h1d); check(ix1, {9'h002, 15'h0006});
    check(ix2, 24'h000000);
    print_verdict;
  end
endmodule // testbench
bind eal_core eal_core_props CHK (.clk_i, .nrst_i, .mem_ack_i, .mem_rdata_i,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .int_done_o, .pc_o,
  .flags_o);
